// ### dv/flash_id_reset_asserts.sv
// Purpose: Concurrent checks on reset events and link output enables
// Assumes: Gating inputs held steady around reset events
// Notes:   Bound into every command block instance
`timescale 1ns/1ps
module flash_id_reset_asserts #(
  parameter int RECOVER_CYC = 40
) (
  input wire logic       REF_CLK,
  input wire logic       RESET_N,
  input wire logic       CE_N,
  input wire logic [3:0] IO_OE,
  input wire logic       RST_HOLD_N,
  input wire logic       QUAD_CMD_MODE,
  input wire logic       QUAD_ENABLE_BIT,
  input wire logic       WRITE_BUSY,
  input wire logic [7:0] NV_READ_PARAM,
  input wire logic [7:0] READ_PARAM,
  input wire logic       RESET_ARMED,
  input wire logic       SOFT_RESET_PULSE,
  input wire logic       HW_RESET_PULSE,
  input wire logic       ABORT_WRITE_PULSE,
  input wire logic       EXIT_POWER_DOWN_PULSE,
  input wire logic       RECOVERING
);
  int rec_cnt;
  int low_cnt;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================================================
  // Run lengths of recovery and of the reset pin low
  always_ff @(posedge REF_CLK) begin
    rec_cnt <= (RESET_N && RECOVERING) ? rec_cnt + 1 : 0;
    low_cnt <= RST_HOLD_N ? 0 : low_cnt + 1;
  end
  // ==========================================================================
  // Checks
  a_soft_one_cycle: assert property (SOFT_RESET_PULSE |=> !SOFT_RESET_PULSE)
    else $error("soft reset pulse longer than one cycle");
  a_soft_needs_arm: assert property (SOFT_RESET_PULSE |-> $past(RESET_ARMED))
    else $error("soft reset without arm");
  a_soft_reload: assert property (SOFT_RESET_PULSE |-> READ_PARAM == $past(NV_READ_PARAM))
    else $error("read register not reloaded by soft reset");
  a_hw_reload: assert property (HW_RESET_PULSE |-> READ_PARAM == $past(NV_READ_PARAM))
    else $error("read register not reloaded by pin reset");
  a_hw_pin_gate: assert property (HW_RESET_PULSE |-> !$past(QUAD_ENABLE_BIT) && $past(READ_PARAM[7]))
    else $error("pin reset while pin function disabled");
  a_hw_min_low: assert property (HW_RESET_PULSE |-> low_cnt >= 20)
    else $error("pin reset after too short a low");
  a_hw_wake_up: assert property (HW_RESET_PULSE |-> EXIT_POWER_DOWN_PULSE)
    else $error("pin reset without power down exit");
  a_abort_when_busy: assert property (ABORT_WRITE_PULSE |-> $past(WRITE_BUSY))
    else $error("abort without write in progress");
  a_recover_start: assert property (SOFT_RESET_PULSE |-> ##[0:1] RECOVERING)
    else $error("recovery not started");
  a_recover_len: assert property ($fell(RECOVERING) |-> rec_cnt >= RECOVER_CYC)
    else $error("recovery too short");
  a_idle_float: assert property (CE_N && $past(CE_N) |-> IO_OE == 4'h0)
    else $error("output driven while deselected");
  a_lane_width: assert property (IO_OE != 4'h0 |-> IO_OE == (QUAD_CMD_MODE ? 4'hf : 4'h2))
    else $error("wrong output enable pattern");
  c_soft: cover property (SOFT_RESET_PULSE);
  c_hw: cover property (HW_RESET_PULSE);
  c_abort: cover property (ABORT_WRITE_PULSE);
endmodule
bind flash_id_reset flash_id_reset_asserts #(.RECOVER_CYC(RECOVER_CYC)) u_asserts (
  .REF_CLK, .RESET_N, .CE_N, .IO_OE, .RST_HOLD_N, .QUAD_CMD_MODE, .QUAD_ENABLE_BIT,
  .WRITE_BUSY, .NV_READ_PARAM, .READ_PARAM, .RESET_ARMED, .SOFT_RESET_PULSE,
  .HW_RESET_PULSE, .ABORT_WRITE_PULSE, .EXIT_POWER_DOWN_PULSE, .RECOVERING);

// ### dv/spi_host_model.sv
// Purpose: Host controller model driving the serial link in frames
// Assumes: Mode 0 framing, 30 ns serial clock, two clocks with select high before each frame
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
module spi_host_model (
  output logic            sclk,
  output logic            ce_n,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  input  wire logic       quad
);
  logic oe_seen;
  initial begin
    sclk = 1'b0;
    ce_n = 1'b1;
    io_in = 4'h0;
    oe_seen = 1'b0;
    repeat (2) tick(4'h0);
  end
  // ==========================================================================
  // One clock: data set while low, sampled on rise
  task automatic tick(input logic [3:0] v);
    io_in = v;
    #15 sclk = 1'b1;
    #15 sclk = 1'b0;
  endtask
  // ==========================================================================
  // One frame: header, dummies, readout
  task automatic frame(input logic [31:0] hdr, input int nb, input int nd, input int nr,
                       output logic [63:0] rd);
    int w;
    w = quad ? 4 : 1;
    rd = '0;
    oe_seen = 1'b0;
    tick(~io_in);
    tick(~io_in);
    ce_n = 1'b0;
    #15;
    for (int i = 0; i < nb; i += w)
      tick(w == 4 ? hdr[31-i -: 4] : {3'h0, hdr[31-i]});
    for (int i = 0; i < nd; i++)
      tick(~io_in);
    for (int i = 0; i < nr; i += w) begin
      #15 sclk = 1'b1;
      rd = (w == 4) ? {rd[59:0], io_out} : {rd[62:0], io_out[1]};
      oe_seen = oe_seen | (io_oe != 4'h0);
      #15 sclk = 1'b0;
    end
    #15 ce_n = 1'b1;
    io_in = ~io_in;
    #30;
  endtask
endmodule

// ### dv/tb_top.sv
// Purpose: Self-checking bench for the identification and reset command block
// Assumes: Core inputs change on falling REF_CLK
// Notes:   Short recovery counts keep the run brief
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %h %h", $time, (a), (e)); end end
module tb_top;
  localparam logic [7:0]   MK  = 8'ha7;    // Arbitrary value
  localparam logic [7:0]   DV  = 8'h3c;    // Arbitrary value
  localparam logic [15:0]  TC  = 16'h5e21; // Arbitrary value
  localparam logic [127:0] SN  = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam logic [127:0] PT  = 128'h0123456789abcdeffedcba9876543210;
  localparam int           REC = 400;
  localparam int           ABT = 800;
  localparam logic [7:0]   NV0 = 8'h40;
  localparam logic [7:0]   NV1 = 8'h48;
  logic        REF_CLK = 1'b0;
  logic        RESET_N, RST_HOLD_N, QUAD_CMD_MODE, QUAD_ENABLE_BIT, WRITE_BUSY, RP_WRITE;
  logic        SERIAL_CLK, CE_N, RESET_ARMED, SOFT_RESET_PULSE, HW_RESET_PULSE;
  logic        ABORT_WRITE_PULSE, EXIT_POWER_DOWN_PULSE, RECOVERING;
  logic [3:0]  IO_IN, IO_OUT, IO_OE;
  logic [7:0]  RP_DATA, READ_PARAM, NV_READ_PARAM;
  logic [63:0] rd;
  int          num_errors = 0, checked = 0, soft_cnt = 0, hw_cnt = 0, abort_cnt = 0;
  always #2.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    if (SOFT_RESET_PULSE === 1'b1) soft_cnt++;
    if (HW_RESET_PULSE === 1'b1) hw_cnt++;
    if (ABORT_WRITE_PULSE === 1'b1) abort_cnt++;
  end
  flash_id_reset #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .TYPE_CAP_CODE(TC), .SERIAL_NUMBER(SN),
    .PARAM_TABLE(PT), .RECOVER_CYC(REC), .ABORT_CYC(ABT)) u_dut (
    .REF_CLK, .RESET_N, .SERIAL_CLK, .CE_N, .IO_IN, .IO_OUT, .IO_OE, .RST_HOLD_N,
    .QUAD_CMD_MODE, .QUAD_ENABLE_BIT, .WRITE_BUSY, .NV_READ_PARAM, .RP_WRITE,
    .RP_DATA, .READ_PARAM, .RESET_ARMED, .SOFT_RESET_PULSE, .HW_RESET_PULSE,
    .ABORT_WRITE_PULSE, .EXIT_POWER_DOWN_PULSE, .RECOVERING);
  spi_host_model u_host (.sclk(SERIAL_CLK), .ce_n(CE_N), .io_in(IO_IN), .io_out(IO_OUT),
    .io_oe(IO_OE), .quad(QUAD_CMD_MODE));
  // ==========================================================================
  // Helpers
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic set_mode(input logic q);
    @(negedge REF_CLK) QUAD_CMD_MODE = q;
  endtask
  task automatic rp_write(input logic [7:0] v);
    @(negedge REF_CLK);
    RP_DATA = v;
    RP_WRITE = 1'b1;
    @(negedge REF_CLK) RP_WRITE = 1'b0;
    @(negedge REF_CLK);
  endtask
  task automatic rd_chk(input logic [31:0] hdr, input int nb, nd, nr, input logic [63:0] e);
    u_host.frame(hdr, nb, nd, nr, rd);
    `CHK(u_host.oe_seen, 1'b1)
    `CHK(rd, e)
  endtask
  task automatic cmd(input logic [7:0] op);
    u_host.frame({op, 24'h0}, 8, 0, 0, rd);
  endtask
  task automatic wait_rec(output int n);
    n = 0;
    while (RECOVERING !== 1'b0 && n < 5000) begin
      @(negedge REF_CLK);
      n++;
    end
    `CHK(n < 5000, 1'b1)
  endtask
  task automatic hw_pulse(input logic qe, input int len);
    @(negedge REF_CLK);
    QUAD_ENABLE_BIT = qe;
    RST_HOLD_N = 1'b0;
    repeat (len) @(negedge REF_CLK);
    RST_HOLD_N = 1'b1;
    repeat (8) @(negedge REF_CLK);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_ident();
    for (int q = 0; q < 2; q++) begin
      set_mode(q[0]);
      rd_chk({q ? 8'haf : 8'h9f, 24'h0}, 8, 0, 48, {16'h0, MK, TC, MK, TC});
      u_host.frame({q ? 8'h9f : 8'haf, 24'h0}, 8, 0, 8, rd);
      `CHK(u_host.oe_seen, 1'b0)
    end
  endtask
  task automatic t_maker();
    for (int i = 0; i < 4; i++) begin
      set_mode(i[1]);
      rd_chk({8'h90, 23'h0, i[0]}, 32, 0, 32,
             i[0] ? {32'h0, DV, MK, DV, MK} : {32'h0, MK, DV, MK, DV});
    end
  endtask
  task automatic t_reads();
    set_mode(1'b0);
    rd_chk({8'h4b, 24'hfe000e}, 32, 8, 32, {32'h0, SN[15:0], SN[127:112]});
    rp_write(8'h30);
    `CHK(READ_PARAM, 8'h30)
    set_mode(1'b1);
    rd_chk({8'h4b, 24'h000003}, 32, 6, 32, {32'h0, SN[103:72]});
    rd_chk({8'h5a, 24'h00000e}, 32, 8, 32, {32'h0, PT[15:0], 16'hffff});
    set_mode(1'b0);
    rd_chk({8'h5a, 24'h0}, 32, 8, 32, {32'h0, PT[127:96]});
  endtask
  task automatic t_soft();
    int s, n;
    s = soft_cnt;
    rp_write(8'hb0);
    cmd(8'h66);
    `CHK(RESET_ARMED, 1'b1)
    cmd(8'h00);
    `CHK(RESET_ARMED, 1'b0)
    cmd(8'h99);
    cmd(8'h66);
    cmd(8'h99);
    `CHK(soft_cnt - s, 1)
    `CHK(READ_PARAM, NV0)
    u_host.frame({8'h9f, 24'h0}, 8, 0, 16, rd);
    `CHK(u_host.oe_seen, 1'b0)
    cmd(8'h66);
    wait_rec(n);
    cmd(8'h99);
    `CHK(soft_cnt - s, 1)
    @(negedge REF_CLK) WRITE_BUSY = 1'b1;
    s = abort_cnt;
    cmd(8'h66);
    cmd(8'h99);
    `CHK(abort_cnt - s, 1)
    wait_rec(n);
    `CHK(n > REC, 1'b1)
    WRITE_BUSY = 1'b0;
  endtask
  task automatic t_hw();
    int h, n;
    h = hw_cnt;
    NV_READ_PARAM = NV1;
    rp_write(8'h80);
    hw_pulse(1'b1, 40);
    hw_pulse(1'b0, 15);
    `CHK(hw_cnt - h, 0)
    hw_pulse(1'b0, 40);
    `CHK(hw_cnt - h, 1)
    `CHK(READ_PARAM, NV1)
    wait_rec(n);
    `CHK(n > REC / 2, 1'b1)
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    {RESET_N, QUAD_CMD_MODE, QUAD_ENABLE_BIT, WRITE_BUSY, RP_WRITE} = 5'h00;
    RST_HOLD_N = 1'b1;
    RP_DATA = 8'h00;
    NV_READ_PARAM = NV0;
    repeat (8) @(negedge REF_CLK);
    RESET_N = 1'b1;
    #200;
    t_ident();
    t_maker();
    t_reads();
    t_soft();
    t_hw();
    end_sim();
  end
  initial begin
    #150000;
    num_errors++;
    end_sim();
  end
endmodule

// ### logic/flash_id_pkg.sv
// Purpose: Shared constants and types for the identification and reset command block
// Assumes: Serial link sampled on rising and driven on falling edges of the serial clock
// Notes:   Identity values live as module parameters, not here
package flash_id_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_STD_ID_SINGLE = 8'h9f;
  localparam logic [7:0] OP_STD_ID_QUAD   = 8'haf;
  localparam logic [7:0] OP_MAKER_DEV     = 8'h90;
  localparam logic [7:0] OP_SERIAL        = 8'h4b;
  localparam logic [7:0] OP_PARAM_TABLE   = 8'h5a;
  localparam logic [7:0] OP_NOP           = 8'h00;
  localparam logic [7:0] OP_RESET_ARM     = 8'h66;
  localparam logic [7:0] OP_RESET_GO      = 8'h99;

  // ==========================================================================
  // Frame counts, in serial clocks
  localparam logic [4:0] OPC_LAST_SINGLE  = 5'h07;
  localparam logic [4:0] OPC_LAST_QUAD    = 5'h01;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
  localparam logic [4:0] ADDR_LAST_QUAD   = 5'h05;
  localparam logic [4:0] BYTE_LAST_SINGLE = 5'h07;
  localparam logic [4:0] BYTE_LAST_QUAD   = 5'h01;
  localparam logic [4:0] TABLE_DUMMY      = 5'h08;
  localparam logic [4:0] DEFAULT_DUMMY    = 5'h08;
  localparam logic [23:0] STD_ID_LAST     = 24'h000002;
  localparam logic [7:0] UNDEFINED_BYTE   = 8'hff;

  // ==========================================================================
  // Read parameter register fields
  localparam int          PIN_SEL_POS    = 7;
  localparam int          DUMMY_MSB      = 6;
  localparam int          DUMMY_LSB      = 3;
  localparam logic [7:0]  READ_PARAM_RST = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int T_RESET_NS      = 100;
  localparam int T_RESET_CYC     = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RECOVER_US    = 35;
  localparam int RECOVER_CYC_DEF = (T_RECOVER_US * 1000) / CLK_PERIOD_NS;
  localparam int ABORT_CYC_DEF   = 2 * RECOVER_CYC_DEF;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_OPC    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_DATA   = 3'b011,
    ST_IGNORE = 3'b100
  } link_state_type;

  typedef enum logic [2:0] {
    CMD_NONE   = 3'b000,
    CMD_STD_ID = 3'b001,
    CMD_MAKER  = 3'b010,
    CMD_SERIAL = 3'b011,
    CMD_TABLE  = 3'b100
  } cmd_type;

  typedef struct packed {
    logic       quad;
    logic [3:0] dummy;
    logic       busy;
  } link_cfg_type;

endpackage

// ### logic/flash_id_reset.sv
// Purpose: Identification, discovery table and reset command handling of a serial flash
// Assumes: Mode, dummy count and busy change only while chip select is high
// Notes:   Link logic runs on the serial clock and is cleared by chip select high
//
// What this block does
// - Opcode 9F single-line or AF four-line returns maker byte then two-byte type code.
// - Every readout bit changes on the falling serial clock edge.
// - Standard identification loops back to the maker byte until chip select rises.
// - Opcode 90 takes two dummy bytes plus one address byte, sampled on rising edges.
// - Address bit zero picks maker-first or device-first order.
// - Maker and device bytes keep alternating while chip select stays low.
// - Opcode 4B takes three address bytes, configured dummies, then sixteen serial bytes.
// - The sixteen-byte serial number wraps to its start while clocked.
// - Serial start byte comes from address bits three to zero; higher bits ignored.
// - Opcode 5A takes three address bytes, eight dummies; chip select high ends it.
// - Four-line table read also waits exactly eight dummy clocks.
// - Undefined table addresses may return any value.
// - Opcode 00 only clears a pending reset arm.
// - Command reset fires only when 66 is followed by 99 in the next frame.
// - Reset reloads the volatile read register from its non-volatile copy.
// - Hold pin acts as reset only when quad enable is zero and select is one.
// - Reset pin low 100ns aborts, leaves power-down, ignores inputs, floats output, reloads.
// - Reset during program or erase aborts it; recovery then takes longer.
// - Hardware reset leaves status and function registers unchanged.
// - Serial read dummy count comes from read register bits six to three.
`timescale 1ns/1ps
module flash_id_reset #(
  parameter logic [7:0]   MAKER_CODE     = 8'h5c,       // Arbitrary value
  parameter logic [7:0]   DEVICE_CODE    = 8'h3a,       // Arbitrary value
  parameter logic [15:0]  TYPE_CAP_CODE  = 16'h4321,    // Arbitrary value
  parameter logic [127:0] SERIAL_NUMBER  = 128'h00112233445566778899aabbccddeeff,
  parameter logic [127:0] PARAM_TABLE    = 128'h53464450_0601_0000_ff00_0601_1000_30ff,
  parameter int           RECOVER_CYC    = flash_id_pkg::RECOVER_CYC_DEF,
  parameter int           ABORT_CYC      = flash_id_pkg::ABORT_CYC_DEF
) (
  input  wire logic       REF_CLK,
  input  wire logic       RESET_N,
  input  wire logic       SERIAL_CLK,
  input  wire logic       CE_N,
  input  wire logic [3:0] IO_IN,
  output logic      [3:0] IO_OUT,
  output logic      [3:0] IO_OE,
  input  wire logic       RST_HOLD_N,
  input  wire logic       QUAD_CMD_MODE,
  input  wire logic       QUAD_ENABLE_BIT,
  input  wire logic       WRITE_BUSY,
  input  wire logic [7:0] NV_READ_PARAM,
  input  wire logic       RP_WRITE,
  input  wire logic [7:0] RP_DATA,
  output logic      [7:0] READ_PARAM,
  output logic            RESET_ARMED,
  output logic            SOFT_RESET_PULSE,
  output logic            HW_RESET_PULSE,
  output logic            ABORT_WRITE_PULSE,
  output logic            EXIT_POWER_DOWN_PULSE,
  output logic            RECOVERING
);

  // ==========================================================================
  // Declarations
  flash_id_pkg::link_state_type state_r, state_nxt;
  flash_id_pkg::cmd_type        cmd_r, cmd_nxt;
  flash_id_pkg::link_cfg_type   cfg_r, cfg_s1, cfg_s2;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [4:0]  dcnt_r, dcnt_nxt;
  logic [23:0] sh_r;
  logic [23:0] addr_r, addr_nxt;
  logic        op_done_r, op_done_nxt;
  logic [7:0]  op_r;
  logic [3:0]  out_r, oe_r;
  logic        done_s1, done_s2, done_s3;
  logic        pin_s1, pin_s2;
  logic        arm_r, arm_nxt;
  logic [7:0]  lowcnt_r;
  logic [31:0] rec_cnt_r;
  logic [7:0]  read_param_r;
  logic        sw_pulse_r, hw_pulse_r, abort_pulse_r, exit_pd_r;

  // ==========================================================================
  // Link decode
  wire logic [23:0] sh_nxt    = cfg_s2.quad ? {sh_r[19:0], IO_IN} : {sh_r[22:0], IO_IN[0]};
  wire logic [7:0]  opcode    = sh_nxt[7:0];
  wire logic [4:0]  opc_last  = cfg_s2.quad ? flash_id_pkg::OPC_LAST_QUAD
                                            : flash_id_pkg::OPC_LAST_SINGLE;
  wire logic [4:0]  addr_last = cfg_s2.quad ? flash_id_pkg::ADDR_LAST_QUAD
                                            : flash_id_pkg::ADDR_LAST_SINGLE;
  wire logic [4:0]  byte_last = cfg_s2.quad ? flash_id_pkg::BYTE_LAST_QUAD
                                            : flash_id_pkg::BYTE_LAST_SINGLE;
  wire logic [4:0]  cfg_dummy = (cfg_s2.dummy == 4'h0) ? flash_id_pkg::DEFAULT_DUMMY
                                                       : {1'b0, cfg_s2.dummy};
  wire logic [4:0]  dummy_n   = (cmd_r == flash_id_pkg::CMD_TABLE) ? flash_id_pkg::TABLE_DUMMY
                                                                   : cfg_dummy;
  wire logic        is_std    = cfg_s2.quad ? (opcode == flash_id_pkg::OP_STD_ID_QUAD)
                                            : (opcode == flash_id_pkg::OP_STD_ID_SINGLE);
  wire logic        table_hit = (addr_r[23:4] == 20'h00000);

  // ==========================================================================
  // Byte selection for readout
  wire logic [7:0] std_byte    = (addr_r[1:0] == 2'b00) ? MAKER_CODE :
                                 (addr_r[1:0] == 2'b01) ? TYPE_CAP_CODE[15:8] :
                                 TYPE_CAP_CODE[7:0];
  wire logic [7:0] maker_byte  = addr_r[0] ? DEVICE_CODE : MAKER_CODE;
  wire logic [7:0] serial_byte = SERIAL_NUMBER[7'(8 * (15 - int'(addr_r[3:0]))) +: 8];
  wire logic [7:0] table_byte  = table_hit ? PARAM_TABLE[7'(8 * (15 - int'(addr_r[3:0]))) +: 8]
                                           : flash_id_pkg::UNDEFINED_BYTE;
  wire logic [7:0] cur_byte    = (cmd_r == flash_id_pkg::CMD_STD_ID) ? std_byte :
                                 (cmd_r == flash_id_pkg::CMD_MAKER)  ? maker_byte :
                                 (cmd_r == flash_id_pkg::CMD_SERIAL) ? serial_byte :
                                 table_byte;
  wire logic       cur_bit     = cur_byte[3'(7 - int'(dcnt_r[2:0]))];
  wire logic [3:0] cur_nib     = dcnt_r[0] ? cur_byte[3:0] : cur_byte[7:4];
  wire logic       drive_en    = (state_r == flash_id_pkg::ST_DATA) && !cfg_s2.busy;

  // ==========================================================================
  // Link state machine
  always_comb begin
    state_nxt   = state_r;
    cmd_nxt     = cmd_r;
    cnt_nxt     = cnt_r + 5'h01;
    dcnt_nxt    = dcnt_r;
    addr_nxt    = addr_r;
    op_done_nxt = op_done_r;
    case (state_r)
      flash_id_pkg::ST_OPC: begin
        if (cnt_r == opc_last) begin
          cnt_nxt   = 5'h00;
          state_nxt = flash_id_pkg::ST_IGNORE;
          addr_nxt  = 24'h000000;
          if (!cfg_s2.busy) begin
            op_done_nxt = 1'b1;
            if (is_std) begin
              cmd_nxt   = flash_id_pkg::CMD_STD_ID;
              state_nxt = flash_id_pkg::ST_DATA;
            end else if (opcode == flash_id_pkg::OP_MAKER_DEV) begin
              cmd_nxt   = flash_id_pkg::CMD_MAKER;
              state_nxt = flash_id_pkg::ST_ADDR;
            end else if (opcode == flash_id_pkg::OP_SERIAL) begin
              cmd_nxt   = flash_id_pkg::CMD_SERIAL;
              state_nxt = flash_id_pkg::ST_ADDR;
            end else if (opcode == flash_id_pkg::OP_PARAM_TABLE) begin
              cmd_nxt   = flash_id_pkg::CMD_TABLE;
              state_nxt = flash_id_pkg::ST_ADDR;
            end
          end
        end
      end
      flash_id_pkg::ST_ADDR: begin
        if (cnt_r == addr_last) begin
          cnt_nxt = 5'h00;
          if (cmd_r == flash_id_pkg::CMD_MAKER) begin
            addr_nxt  = {23'h000000, sh_nxt[0]};
            state_nxt = flash_id_pkg::ST_DATA;
          end else if (cmd_r == flash_id_pkg::CMD_SERIAL) begin
            addr_nxt  = {20'h00000, sh_nxt[3:0]};
            state_nxt = flash_id_pkg::ST_DUMMY;
          end else begin
            addr_nxt  = sh_nxt;
            state_nxt = flash_id_pkg::ST_DUMMY;
          end
        end
      end
      flash_id_pkg::ST_DUMMY: begin
        if (cnt_r == dummy_n - 5'h01) begin
          cnt_nxt   = 5'h00;
          state_nxt = flash_id_pkg::ST_DATA;
        end
      end
      flash_id_pkg::ST_DATA: begin
        cnt_nxt  = 5'h00;
        dcnt_nxt = dcnt_r + 5'h01;
        if (dcnt_r == byte_last) begin
          dcnt_nxt = 5'h00;
          if (cmd_r == flash_id_pkg::CMD_STD_ID) begin
            addr_nxt = (addr_r == flash_id_pkg::STD_ID_LAST) ? 24'h000000
                                                             : addr_r + 24'h000001;
          end else if (cmd_r == flash_id_pkg::CMD_MAKER) begin
            addr_nxt = {23'h000000, ~addr_r[0]};
          end else if (cmd_r == flash_id_pkg::CMD_SERIAL) begin
            addr_nxt = {20'h00000, addr_r[3:0] + 4'h1};
          end else begin
            addr_nxt = addr_r + 24'h000001;
          end
        end
      end
      default: begin
        cnt_nxt = 5'h00;
      end
    endcase
  end

  // ==========================================================================
  // Link registers, rising edge; chip select high ends the frame
  always_ff @(posedge SERIAL_CLK or posedge CE_N) begin
    if (CE_N) begin
      state_r   <= flash_id_pkg::ST_OPC;
      cmd_r     <= flash_id_pkg::CMD_NONE;
      cnt_r     <= 5'h00;
      dcnt_r    <= 5'h00;
      addr_r    <= 24'h000000;
      op_done_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cmd_r     <= cmd_nxt;
      cnt_r     <= cnt_nxt;
      dcnt_r    <= dcnt_nxt;
      addr_r    <= addr_nxt;
      op_done_r <= op_done_nxt;
    end
  end

  // ==========================================================================
  // Input shift and opcode capture, sampled on rising edge
  always_ff @(posedge SERIAL_CLK) begin
    sh_r <= sh_nxt;
    if (state_r == flash_id_pkg::ST_OPC && cnt_r == opc_last) begin
      op_r <= opcode;
    end
  end

  // ==========================================================================
  // Configuration into the link domain
  always_ff @(posedge SERIAL_CLK) begin
    cfg_s1 <= cfg_r;
    cfg_s2 <= cfg_s1;
  end

  // ==========================================================================
  // Output drive on falling edge
  always_ff @(negedge SERIAL_CLK or posedge CE_N) begin
    if (CE_N) begin
      out_r <= 4'h0;
      oe_r  <= 4'h0;
    end else begin
      out_r <= cfg_s2.quad ? cur_nib : {2'b00, cur_bit, 1'b0};
      oe_r  <= !drive_en ? 4'h0 : (cfg_s2.quad ? 4'hf : 4'h2);
    end
  end

  assign IO_OUT = out_r;
  assign IO_OE  = oe_r;

  // ==========================================================================
  // Core-domain crossing and reset control
  wire logic op_evt   = done_s2 && !done_s3;
  wire logic pin_en   = !QUAD_ENABLE_BIT && read_param_r[flash_id_pkg::PIN_SEL_POS];
  wire logic pin_low  = pin_en && !pin_s2;
  wire logic low_full = (int'(lowcnt_r) == flash_id_pkg::T_RESET_CYC);
  wire logic hw_fire  = pin_low && (int'(lowcnt_r) == flash_id_pkg::T_RESET_CYC - 1);
  wire logic sw_fire  = op_evt && arm_r && (op_r == flash_id_pkg::OP_RESET_GO);
  wire logic rst_fire = hw_fire || sw_fire;
  wire logic busy_w   = (rec_cnt_r != 32'h00000000) || (pin_low && low_full);
  wire logic [31:0] rec_load = WRITE_BUSY ? 32'(ABORT_CYC) : 32'(RECOVER_CYC);

  // ==========================================================================
  // Any frame decoded outside recovery other than the arm opcode, the no-op included, drops the arm
  always_comb begin
    arm_nxt = arm_r;
    if (rst_fire) begin
      arm_nxt = 1'b0;
    end else if (op_evt) begin
      arm_nxt = (op_r == flash_id_pkg::OP_RESET_ARM);
    end
  end

  // ==========================================================================
  // Two-stage synchronisers into the core clock
  always_ff @(posedge REF_CLK) begin
    done_s1 <= op_done_r;
    done_s2 <= done_s1;
    pin_s1  <= RST_HOLD_N;
    pin_s2  <= pin_s1;
  end

  // ==========================================================================
  // Reset arm and completion edge
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      done_s3 <= 1'b0;
      arm_r   <= 1'b0;
    end else begin
      done_s3 <= done_s2;
      arm_r   <= arm_nxt;
    end
  end

  // ==========================================================================
  // Pin low-time counter
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || !pin_low) begin
      lowcnt_r <= 8'h00;
    end else if (!low_full) begin
      lowcnt_r <= lowcnt_r + 8'h01;
    end
  end

  // ==========================================================================
  // Recovery wait; a write in progress makes it longer
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      rec_cnt_r <= 32'h00000000;
    end else if (rst_fire) begin
      rec_cnt_r <= rec_load;
    end else if (rec_cnt_r != 32'h00000000) begin
      rec_cnt_r <= rec_cnt_r - 32'h00000001;
    end
  end

  // ==========================================================================
  // Volatile read register; status and function registers are not held here
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || rst_fire) begin
      read_param_r <= NV_READ_PARAM;
    end else if (RP_WRITE) begin
      read_param_r <= RP_DATA;
    end
  end

  // ==========================================================================
  // Event pulses and link configuration
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      sw_pulse_r    <= 1'b0;
      hw_pulse_r    <= 1'b0;
      abort_pulse_r <= 1'b0;
      exit_pd_r     <= 1'b0;
      cfg_r         <= '{quad: 1'b0, dummy: 4'h0, busy: 1'b0};
    end else begin
      sw_pulse_r    <= sw_fire;
      hw_pulse_r    <= hw_fire;
      abort_pulse_r <= rst_fire && WRITE_BUSY;
      exit_pd_r     <= hw_fire;
      cfg_r         <= '{quad:  QUAD_CMD_MODE,
                         dummy: read_param_r[flash_id_pkg::DUMMY_MSB:flash_id_pkg::DUMMY_LSB],
                         busy:  busy_w};
    end
  end

  assign READ_PARAM            = read_param_r;
  assign RESET_ARMED           = arm_r;
  assign SOFT_RESET_PULSE      = sw_pulse_r;
  assign HW_RESET_PULSE        = hw_pulse_r;
  assign ABORT_WRITE_PULSE     = abort_pulse_r;
  assign EXIT_POWER_DOWN_PULSE = exit_pd_r;
  assign RECOVERING            = cfg_r.busy;

endmodule
